// File: core/ppc_device.sv
// Programmer end of the command port: latches, status word, read logic
// Notes on behaviour
// - Host checks busy bit before starting
// - Status word on read bus outside data read cycles
// - Status strobe answered by acknowledge only
// - Bit 0 busy during program operation
// - Bits 1-3: done, fail, fused bit
// - Bits 4-7: range, hardware, card, orientation
// - One status bit only; ignore others busy
// - Control byte with its strobe, top zero
// - Control bit 6 starts a read
// - Control bit 5 selects socket one
// - Control bit 4 picks programmed nibble
// - Address is upper nibble plus low byte
// - Program strobe latches data, sets busy
// - Programming continues after strobe release
// - Programming indicator while writing target
// - Update status, then clear busy
// - Host polls busy, then reads status
// - Read strobe returns data with acknowledge
// - Host releases strobe on acknowledge
// - Prefetched data acknowledged within one microsecond
// - Four-bit data in low half
// - Strobe release restores status on bus
// - Strobes, acknowledge and data active low
`timescale 1ns/1ps
module ppc_device
  import ppc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  ppc_link_if.dev link,
  output logic [ADDR_W-1:0] tgtAddr,
  output logic [DATA_W-1:0] tgtWrData,
  output logic tgtSocket1,
  output logic tgtCtrlSpare,
  output logic tgtReq,
  output logic tgtWrite,
  input wire logic tgtDone,
  input wire logic [CODE_W-1:0] tgtResult,
  input wire logic [DATA_W-1:0] tgtRdData,
  input wire logic tgtFourBit,
  input wire logic cardPresent,
  input wire logic [ADDR_W-1:0] tgtLastAddr,
  output logic programming,
  output logic program_active_latch_n,
  output logic [7:0] statusWord
);
  typedef struct packed {
    ppc_dev_st_type st;
    ppc_op_type op;
    logic prevCtrl;
    logic prevLow;
    logic prevProg;
    logic prevRead;
    logic [7:0] ctrlByte;
    logic [7:0] lowByte;
    logic [7:0] wrByte;
    logic [CODE_W-1:0] code;
    logic [7:0] rdData;
    logic rdValid;
    logic dataCyc;
    logic ackN;
    logic [7:0] busN;
  } ppc_dev_type;

  ppc_dev_type s;
  ppc_dev_type next_s;
  logic [7:0] hostData;
  logic ctrlOn;
  logic lowOn;
  logic progOn;
  logic readOn;
  logic statusOn;
  logic [ADDR_W-1:0] addr;

  // Strobes and data lines are active low on the link
  assign hostData = ~link.host_data_n;
  assign ctrlOn = !link.ctrl_upper_addr_strobe_n;
  assign lowOn = !link.lower_addr_strobe_n;
  assign progOn = !link.program_data_strobe_n;
  assign readOn = !link.read_data_strobe_n;
  assign statusOn = !link.read_status_strobe_n;
  assign addr = {s.ctrlByte[CTL_HI_MSB:0], s.lowByte};

  // One-hot status word from the stored code
  ppc_status_decoder ppc_status_decoder_i (
    .code(s.code),
    .word(statusWord)
  );

  // Next-state logic
  always_comb
  begin
    next_s = s;
    next_s.prevCtrl = ctrlOn;
    next_s.prevLow = lowOn;
    next_s.prevProg = progOn;
    next_s.prevRead = readOn;
    case (s.st)
      DS_IDLE:
      begin
        if (lowOn && !s.prevLow)
        begin
          next_s.lowByte = hostData;
        end
        if (ctrlOn && !s.prevCtrl)
        begin
          next_s.ctrlByte = hostData;
          next_s.rdValid = 1'b0;
          if (hostData[CTL_START_RD])
          begin
            next_s.op = OP_PREFETCH;
            next_s.code = ST_BUSY;
            next_s.st = DS_CHECK;
          end
        end
        else if (progOn && !s.prevProg)
        begin
          next_s.wrByte = hostData;
          next_s.op = OP_PROG;
          next_s.code = ST_BUSY;
          next_s.rdValid = 1'b0;
          next_s.st = DS_CHECK;
        end
        else if (readOn && !s.prevRead)
        begin
          next_s.dataCyc = 1'b1;
          next_s.busN = BYTE_ONES;
          if (s.rdValid)
          begin
            // Prefetched data answered at once
            next_s.busN = ~s.rdData;
            next_s.ackN = 1'b0;
            next_s.rdValid = 1'b0;
            next_s.st = DS_ACK;
          end
          else
          begin
            next_s.op = OP_FETCH;
            next_s.code = ST_BUSY;
            next_s.st = DS_CHECK;
          end
        end
      end
      DS_CHECK:
      begin
        // Card and range are checked before the target is touched
        if (!cardPresent)
        begin
          next_s.code = ST_NOCARD;
        end
        else if (addr > tgtLastAddr)
        begin
          next_s.code = ST_RANGE;
        end
        if (!cardPresent || addr > tgtLastAddr)
        begin
          next_s.rdData = '0;
          next_s.st = DS_IDLE;
          if (s.op == OP_FETCH)
          begin
            next_s.busN = ~next_s.rdData;
            next_s.ackN = 1'b0;
            next_s.st = DS_ACK;
          end
        end
        else
        begin
          next_s.st = DS_RUN;
        end
      end
      DS_RUN:
      begin
        // Runs to completion regardless of the strobe
        if (tgtDone)
        begin
          next_s.code = tgtResult;
          next_s.st = DS_IDLE;
          if (s.op != OP_PROG)
          begin
            next_s.rdData = tgtFourBit ? {NIBBLE_ZERO, tgtRdData[3:0]} : tgtRdData;
            next_s.rdValid = (s.op == OP_PREFETCH) && (tgtResult == ST_DONE);
          end
          if (s.op == OP_FETCH)
          begin
            next_s.busN = ~next_s.rdData;
            next_s.ackN = 1'b0;
            next_s.st = DS_ACK;
          end
        end
      end
      DS_ACK:
      begin
        // Hold data and acknowledge until the strobe is released
        if (!readOn)
        begin
          next_s.ackN = 1'b1;
          next_s.dataCyc = 1'b0;
          next_s.st = DS_IDLE;
        end
      end
      default:
      begin
        next_s.st = DS_IDLE;
      end
    endcase
    // Outside data cycles: status on the bus, status strobe acknowledged
    if (!next_s.dataCyc)
    begin
      next_s.busN = ~statusWord;
      next_s.ackN = !statusOn;
    end
  end

  // State register; reset leaves the port idle and not busy
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '{st: DS_IDLE, op: OP_PROG, code: ST_DONE, ackN: 1'b1, busN: ~8'h02, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Target side outputs, then acknowledge and read bus to the link
  assign tgtAddr = addr;
  assign tgtSocket1 = s.ctrlByte[CTL_SOCKET];
  assign tgtCtrlSpare = s.ctrlByte[CTL_SPARE];
  assign tgtReq = (s.st == DS_RUN);
  assign tgtWrite = (s.op == OP_PROG);
  assign tgtWrData = !tgtFourBit ? s.wrByte :
    (s.ctrlByte[CTL_NIBBLE] ? {NIBBLE_ZERO, s.wrByte[7:4]} : {NIBBLE_ZERO, s.wrByte[3:0]});
  assign programming = (s.st == DS_RUN) && (s.op == OP_PROG);
  assign program_active_latch_n = !((s.st != DS_IDLE) && (s.op == OP_PROG) && (s.st != DS_ACK));
  assign link.host_ack_n = s.ackN;
  assign link.readBus_n = s.busN;
endmodule

// File: core/ppc_pkg.sv
// Shared constants and types for the programmer command port
package ppc_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int CODE_W = 3;
  // Status word bit positions (one-hot)
  localparam logic [2:0] ST_BUSY = 3'h0;
  localparam logic [2:0] ST_DONE = 3'h1;
  localparam logic [2:0] ST_FAIL = 3'h2;
  localparam logic [2:0] ST_FUSED = 3'h3;
  localparam logic [2:0] ST_RANGE = 3'h4;
  localparam logic [2:0] ST_HWFAIL = 3'h5;
  localparam logic [2:0] ST_NOCARD = 3'h6;
  localparam logic [2:0] ST_ORIENT = 3'h7;
  // Control and upper address byte fields
  localparam int CTL_SPARE = 7;
  localparam int CTL_START_RD = 6;
  localparam int CTL_SOCKET = 5;
  localparam int CTL_NIBBLE = 4;
  localparam int CTL_HI_MSB = 3;
  localparam logic [7:0] CTL_WRITE_MASK = 8'h7f;
  localparam logic [3:0] NIBBLE_ZERO = 4'h0;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  // Read acknowledge limit for the prefetch method
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACK_LIMIT_NS = 1000;
  localparam int ACK_LIMIT_CYC = ACK_LIMIT_NS / CLK_PERIOD_NS;
  localparam logic [7:0] ACK_LIMIT_CNT = 8'(ACK_LIMIT_CYC);
  // Host write strobe width in cycles
  localparam logic [7:0] STROBE_CNT = 8'h02;
  localparam logic [7:0] CNT_ONE = 8'h01;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  // Host command port offsets (byte addresses)
  localparam logic [7:0] HREG_CTRL = 8'h00;
  localparam logic [7:0] HREG_LADDR = 8'h04;
  localparam logic [7:0] HREG_PDATA = 8'h08;
  localparam logic [7:0] HREG_RSTAT = 8'h0c;
  localparam logic [7:0] HREG_RDATA = 8'h10;
  localparam logic [7:0] HREG_INFO = 8'h14;
  typedef enum logic [2:0] {DS_IDLE, DS_CHECK, DS_RUN, DS_ACK} ppc_dev_st_type;
  typedef enum logic [1:0] {OP_PROG, OP_PREFETCH, OP_FETCH} ppc_op_type;
  typedef enum logic [1:0] {HS_IDLE, HS_WSTROBE, HS_RWAIT} ppc_host_st_type;
endpackage

// File: core/ppc_link_if.sv
// Parallel byte link between control computer and programmer
`timescale 1ns/1ps
interface ppc_link_if;
  logic [7:0] host_data_n;
  logic ctrl_upper_addr_strobe_n;
  logic lower_addr_strobe_n;
  logic program_data_strobe_n;
  logic read_data_strobe_n;
  logic read_status_strobe_n;
  logic host_ack_n;
  logic [7:0] readBus_n;
  modport dev (
    input host_data_n, ctrl_upper_addr_strobe_n, lower_addr_strobe_n, program_data_strobe_n,
    input read_data_strobe_n, read_status_strobe_n,
    output host_ack_n, readBus_n
  );
  modport host (
    output host_data_n, ctrl_upper_addr_strobe_n, lower_addr_strobe_n, program_data_strobe_n,
    output read_data_strobe_n, read_status_strobe_n,
    input host_ack_n, readBus_n
  );
endinterface

// File: core/ppc_status_decoder.sv
// Three-bit status code to one-hot status word
`timescale 1ns/1ps
module ppc_status_decoder
  import ppc_pkg::*;
(
  input wire logic [CODE_W-1:0] code,
  output logic [7:0] word
);
  // One bit per condition, only the coded one high
  for (genvar i = 0; i < 8; i++)
  begin : g_bit
    assign word[i] = (code == CODE_W'(i));
  end
endmodule

// File: core/ppc_host.sv
// Control computer end: strobe sequencer behind a small register port
`timescale 1ns/1ps
module ppc_host
  import ppc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  ppc_link_if.host link,
  input wire logic [7:0] cmdAddr,
  input wire logic [31:0] cmdWdata,
  input wire logic cmdWrite,
  input wire logic cmdRead,
  output logic [31:0] cmdRdata
);
  typedef struct packed {
    ppc_host_st_type st;
    logic [4:0] strobes;
    logic [7:0] cnt;
    logic [7:0] dataOut;
    logic [7:0] lastStatus;
    logic [7:0] lastData;
    logic timeout;
    logic [31:0] rdata;
  } ppc_host_type;

  // Strobe positions inside the strobes field
  localparam int SB_CTRL = 0;
  localparam int SB_LOW = 1;
  localparam int SB_PROG = 2;
  localparam int SB_RDATA = 3;
  localparam int SB_RSTAT = 4;

  ppc_host_type s;
  ppc_host_type next_s;
  logic [7:0] statusView;

  // Bits 1-7 hidden while the device reports busy
  assign statusView = s.lastStatus[ST_BUSY] ? {7'h00, 1'b1} : s.lastStatus;

  // Next-state logic
  always_comb
  begin
    next_s = s;
    next_s.rdata = '0;
    if (cmdRead && cmdAddr == HREG_INFO)
    begin
      next_s.rdata = {6'h00, s.timeout, (s.st != HS_IDLE), s.lastData, 8'h00, statusView};
    end
    case (s.st)
      HS_IDLE:
      begin
        if (cmdWrite)
        begin
          next_s.dataOut = cmdWdata[7:0];
          next_s.cnt = STROBE_CNT;
          next_s.st = HS_WSTROBE;
          case (cmdAddr)
            HREG_CTRL:
            begin
              next_s.dataOut = cmdWdata[7:0] & CTL_WRITE_MASK;
              next_s.strobes[SB_CTRL] = 1'b1;
            end
            HREG_LADDR: next_s.strobes[SB_LOW] = 1'b1;
            HREG_PDATA: next_s.strobes[SB_PROG] = 1'b1;
            HREG_RSTAT:
            begin
              next_s.strobes[SB_RSTAT] = 1'b1;
              next_s.cnt = ACK_LIMIT_CNT;
              next_s.st = HS_RWAIT;
            end
            HREG_RDATA:
            begin
              next_s.strobes[SB_RDATA] = 1'b1;
              next_s.cnt = ACK_LIMIT_CNT;
              next_s.st = HS_RWAIT;
            end
            default: next_s.st = HS_IDLE;
          endcase
          if (next_s.st == HS_RWAIT)
          begin
            next_s.timeout = 1'b0;
          end
        end
      end
      HS_WSTROBE:
      begin
        next_s.cnt = s.cnt - CNT_ONE;
        if (s.cnt == CNT_ONE)
        begin
          next_s.strobes = '0;
          next_s.st = HS_IDLE;
        end
      end
      HS_RWAIT:
      begin
        if (!link.host_ack_n)
        begin
          // Capture and release on the acknowledge
          if (s.strobes[SB_RSTAT])
          begin
            next_s.lastStatus = ~link.readBus_n;
          end
          else
          begin
            next_s.lastData = ~link.readBus_n;
          end
          next_s.strobes = '0;
          next_s.st = HS_IDLE;
        end
        else if (s.cnt == CNT_ZERO)
        begin
          next_s.timeout = 1'b1;
          next_s.strobes = '0;
          next_s.st = HS_IDLE;
        end
        else
        begin
          next_s.cnt = s.cnt - CNT_ONE;
        end
      end
      default:
      begin
        next_s.st = HS_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '{st: HS_IDLE, default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  // Link drive, all active low; register port read data
  assign link.host_data_n = ~s.dataOut;
  assign link.ctrl_upper_addr_strobe_n = !s.strobes[SB_CTRL];
  assign link.lower_addr_strobe_n = !s.strobes[SB_LOW];
  assign link.program_data_strobe_n = !s.strobes[SB_PROG];
  assign link.read_data_strobe_n = !s.strobes[SB_RDATA];
  assign link.read_status_strobe_n = !s.strobes[SB_RSTAT];
  assign cmdRdata = s.rdata;
endmodule

// File: dv/ppc_link_monitor.sv
// Protocol checks on the parallel command link
`timescale 1ns/1ps
module ppc_link_monitor
  import ppc_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] host_data_n,
  input wire logic ctrl_upper_addr_strobe_n,
  input wire logic lower_addr_strobe_n,
  input wire logic program_data_strobe_n,
  input wire logic read_data_strobe_n,
  input wire logic read_status_strobe_n,
  input wire logic host_ack_n,
  input wire logic [7:0] readBus_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // Read strobes and acknowledge
  chk_status_ack: assert property (!read_status_strobe_n && $past(!read_status_strobe_n) |-> !host_ack_n)
    else $error("status read not acknowledged");
  chk_ack_release: assert property ((read_status_strobe_n && read_data_strobe_n) [*2] |-> host_ack_n)
    else $error("acknowledge held after release");
  chk_data_ack_bound: assert property ($fell(read_data_strobe_n) |-> ##[1:40] !host_ack_n)
    else $error("data read not acknowledged in time");
  chk_data_stable: assert property (!host_ack_n && !read_data_strobe_n && $past(!host_ack_n) |-> $stable(readBus_n))
    else $error("read data moved under acknowledge");
  // Status word on the read bus
  chk_status_onehot: assert property (read_data_strobe_n [*2] |-> $onehot(~readBus_n))
    else $error("status word not one-hot");
  chk_prog_busy: assert property ($fell(program_data_strobe_n) && readBus_n[ST_BUSY] && host_ack_n
    && read_data_strobe_n |-> ##2 !readBus_n[ST_BUSY])
    else $error("busy not raised by program strobe");
  // Host write strobes, then cover points for program, data read and status read
  chk_ctrl_width: assert property ($fell(ctrl_upper_addr_strobe_n) |=> !ctrl_upper_addr_strobe_n
    ##1 ctrl_upper_addr_strobe_n)
    else $error("control strobe width wrong");
  chk_spare_low: assert property (!ctrl_upper_addr_strobe_n |-> host_data_n[CTL_SPARE])
    else $error("spare control bit driven true");
  cov_prog: cover property ($fell(program_data_strobe_n));
  cov_data: cover property (!host_ack_n && !read_data_strobe_n);
  cov_stat: cover property (!host_ack_n && !read_status_strobe_n && lower_addr_strobe_n);
endmodule

// File: dv/ppc_tb.sv
// Self-checking bench joining both ends of the command link
`timescale 1ns/1ps
module ppc_tb;
  import ppc_pkg::*;
  logic clk, arst_n, cmdWrite, cmdRead, tgtFourBit, cardPresent, tgtReq, tgtWrite;
  logic tgtDone = 1'b0;
  logic tgtSocket1, tgtCtrlSpare, programming, program_active_latch_n;
  logic [7:0] cmdAddr, tgtRdData, statusWord;
  logic [31:0] cmdWdata, cmdRdata, info;
  logic [ADDR_W-1:0] tgtAddr, tgtLastAddr;
  logic [DATA_W-1:0] tgtWrData;
  logic [CODE_W-1:0] tgtResult;
  logic [2:0] codes [5] = '{3'h1, 3'h2, 3'h3, 3'h5, 3'h7};
  logic [7:0] expData [3] = '{8'h5a, 8'h00, 8'h00};
  logic [7:0] expStat [3] = '{8'h02, 8'h10, 8'h40};
  int err_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int tgtCnt = 0;
  ppc_link_if link();
  ppc_device ppc_device_i(.clk(clk), .arst_n(arst_n), .link(link), .tgtAddr(tgtAddr), .tgtWrData(tgtWrData),
    .tgtSocket1(tgtSocket1), .tgtCtrlSpare(tgtCtrlSpare), .tgtReq(tgtReq), .tgtWrite(tgtWrite),
    .tgtDone(tgtDone), .tgtResult(tgtResult), .tgtRdData(tgtRdData), .tgtFourBit(tgtFourBit),
    .cardPresent(cardPresent), .tgtLastAddr(tgtLastAddr), .programming(programming),
    .program_active_latch_n(program_active_latch_n), .statusWord(statusWord));
  ppc_host ppc_host_i(.clk(clk), .arst_n(arst_n), .link(link), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
    .cmdWrite(cmdWrite), .cmdRead(cmdRead), .cmdRdata(cmdRdata));
  ppc_link_monitor ppc_link_monitor_i(.clk(clk), .arst_n(arst_n), .host_data_n(link.host_data_n),
    .ctrl_upper_addr_strobe_n(link.ctrl_upper_addr_strobe_n), .lower_addr_strobe_n(link.lower_addr_strobe_n),
    .program_data_strobe_n(link.program_data_strobe_n), .read_data_strobe_n(link.read_data_strobe_n),
    .read_status_strobe_n(link.read_status_strobe_n), .host_ack_n(link.host_ack_n), .readBus_n(link.readBus_n));
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Target stand-in, answers each request after a fixed delay
  always @(posedge clk)
  begin
    tgtDone <= 1'b0;
    if (tgtReq && !tgtDone) tgtCnt <= tgtCnt + 1;
    if (tgtCnt == 20)
    begin
      tgtDone <= 1'b1;
      tgtCnt <= 0;
    end
  end
  // Hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      test_done();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rdInfo(input logic [7:0] a);
    @(posedge clk);
    cmdAddr <= a;
    cmdRead <= 1'b1;
    @(posedge clk);
    cmdRead <= 1'b0;
    #1 info = cmdRdata;
  endtask
  // Poll the info word until a flag drops; busy needs a fresh status fetch
  task automatic waitClear(input int b);
    for (int i = 0; i < 300; i++)
    begin
      if (b == 0) wr(HREG_RSTAT, 8'h00);
      rdInfo(HREG_INFO);
      if (info[b] !== 1'b1) break;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    cmdAddr <= a;
    cmdWdata <= {24'h0, d};
    cmdWrite <= 1'b1;
    @(posedge clk);
    cmdWrite <= 1'b0;
    waitClear(24);
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    arst_n = 1'b0;
    {cmdWrite, cmdRead, tgtFourBit} = 3'h0;
    {cmdAddr, cmdWdata} = 40'h0;
    cardPresent = 1'b1;
    tgtLastAddr = 12'hfff;
    tgtRdData = 8'h5a;
    tgtResult = 3'h1;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    wr(HREG_RSTAT, 8'h00);
    rdInfo(HREG_INFO);
    chk("reset status", info[7:0], 8'h02);
    chk("reset outputs", {programming, program_active_latch_n}, 2'b01);
    $display("test reset done");
    wr(HREG_CTRL, 8'haa);
    wr(HREG_LADDR, 8'h5c);
    chk("address", tgtAddr, 12'ha5c);
    chk("socket and spare", {tgtSocket1, tgtCtrlSpare}, 2'b10);
    $display("test address done");
    foreach (codes[i])
    begin
      tgtResult <= codes[i];
      tgtFourBit <= i[0];
      wr(HREG_PDATA, 8'h96);
      repeat (4) @(posedge clk);
      #1;
      chk("prog latch", program_active_latch_n, 1'b0);
      chk("prog indicator", {programming, tgtWrite}, 2'b11);
      chk("prog data", tgtWrData, i[0] ? 8'h06 : 8'h96);
      wr(HREG_RSTAT, 8'h00);
      rdInfo(HREG_INFO);
      chk("busy status", info[7:0], 8'h01);
      waitClear(0);
      rdInfo(HREG_INFO);
      chk("result status", info[7:0], 8'h01 << codes[i]);
      chk("status word", statusWord, 8'h01 << codes[i]);
      chk("prog end", {programming, program_active_latch_n}, 2'b01);
    end
    $display("test program done");
    tgtResult <= 3'h1;
    for (int k = 0; k < 3; k++)
    begin
      cardPresent <= (k != 2);
      tgtLastAddr <= (k == 1) ? 12'h100 : 12'hfff;
      wr(HREG_RDATA, 8'h00);
      wr(HREG_RSTAT, 8'h00);
      rdInfo(HREG_INFO);
      chk("fetch data", info[25:16], {2'b00, expData[k]});
      chk("fetch status", info[7:0], expStat[k]);
    end
    $display("test fetch done");
    tgtLastAddr <= 12'hfff;
    cardPresent <= 1'b1;
    tgtRdData <= 8'h3c;
    wr(HREG_CTRL, 8'h6a);
    repeat (4) @(posedge clk);
    wr(HREG_RSTAT, 8'h00);
    rdInfo(HREG_INFO);
    chk("prefetch busy", info[7:0], 8'h01);
    waitClear(0);
    tgtRdData <= 8'hc3;
    wr(HREG_RDATA, 8'h00);
    rdInfo(HREG_INFO);
    chk("prefetch data", info[25:16], {2'b00, 8'h3c});
    wr(HREG_RSTAT, 8'h00);
    rdInfo(HREG_INFO);
    chk("status ack", info[25:24], 2'b00);
    chk("prefetch status", info[7:0], 8'h02);
    $display("test prefetch done");
    tgtFourBit <= 1'b1;
    wr(HREG_CTRL, 8'h1a);
    chk("upper nibble", tgtWrData, 8'h09);
    chk("socket two", tgtSocket1, 1'b0);
    rdInfo(8'h20);
    chk("unmapped", info, 32'h0);
    wr(HREG_RDATA, 8'h00);
    rdInfo(HREG_INFO);
    chk("four bit data", info[23:16], 8'h03);
    $display("test nibble done");
    test_done();
  end
endmodule
